/* File: hw/spx_defines.svh */
// constants for the stack pointer extended operations block
`ifndef SPX_DEFINES_SVH
`define SPX_DEFINES_SVH
`define SPX_OPC_PUSH 8'h_EA
`define SPX_OPC_PSUB 8'h_E9
`define SPX_SEL_RET 2'h_3
`define SPX_SEL_FRAME 2'h_2
`define SPX_PTR_W 12
`define SPX_PC_W 21
`define SPX_PHASES 3'h_4
`define SPX_PHASE_FIRST 2'h_0
`define SPX_PHASE_LAST 2'h_3
`endif

/* File: hw/spx_exec.sv */
// decode and execute for push-literal, pointer-subtract and subtract-and-return
//
// Contract
// - opcode 0xEA pushes its low byte to memory at the frame pointer
// - frame pointer decrements by one after the store, old value addresses
// - opcode 0xE9 carries a two-bit selector and six-bit literal
// - selected pointer minus unsigned literal is written back to it
// - selector 11 means subtract-and-return acting on the frame pointer
// - subtract-and-return then loads program counter from return stack top
// - subtract-and-return takes two cycles, second is a no operation
// - opcodes recognised only while the extended set enable is high
`timescale 1ns/1ps
`default_nettype none
`include "spx_defines.svh"
module spx_exec (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic extended_set_enable,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [35:0] indirect_pointer,
  input wire logic [20:0] return_stack_top,
  output spx_pkg::spx_mem_wr_t mem_wr,
  output spx_pkg::spx_ptr_wr_t ptr_wr,
  output logic pc_load,
  output logic [20:0] pc_value,
  output logic stack_pop,
  output logic busy,
  output logic instr_taken
);
  import spx_pkg::*;

  spx_state_t state_reg, state_next;
  logic [15:0] instr_reg;
  spx_mem_wr_t mem_wr_reg, mem_wr_next;
  spx_ptr_wr_t ptr_wr_reg, ptr_wr_next;
  logic pc_load_reg, pc_load_next;
  logic [20:0] pc_value_reg, pc_value_next;
  logic stack_pop_reg, stack_pop_next;
  logic taken_reg;
  logic busy_reg;
  wire logic [1:0] phase;
  wire logic cycle_end;

  // pick one 12-bit pointer out of the flattened set
  function automatic logic [11:0] ptr_pick(input logic [35:0] all, input logic [1:0] s);
    ptr_pick = all[12*s +: 12];
  endfunction

  spx_phase u_phase (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // decode of the captured word
  // gated by extended set
  wire logic is_push = extended_set_enable && (instr_reg[15:8] == `SPX_OPC_PUSH);
  wire logic is_psub = extended_set_enable && (instr_reg[15:8] == `SPX_OPC_PSUB);
  wire logic [1:0] sel_f = instr_reg[7:6];
  wire logic [5:0] lit_k = instr_reg[5:0];
  wire logic is_ret = is_psub && (sel_f == `SPX_SEL_RET);
  wire logic [1:0] tgt_sel = is_ret ? `SPX_SEL_FRAME : sel_f;
  wire logic [11:0] frame_ptr = ptr_pick(indirect_pointer, `SPX_SEL_FRAME);
  wire logic [11:0] tgt_ptr = ptr_pick(indirect_pointer, tgt_sel);
  wire logic [11:0] sub_val = tgt_ptr - {6'h_0, lit_k};
  wire logic [11:0] dec_val = frame_ptr - 12'h_001;
  // capture window, idle and first phase
  wire logic capture_ok = (state_reg == SPX_IDLE) && instr_valid
    && (phase == `SPX_PHASE_FIRST);

  // next-state and output selection, entry at the q1 edge and results at the q4 edge
  always_comb begin
    state_next = state_reg;
    mem_wr_next = '0;
    ptr_wr_next = '0;
    pc_load_next = 1'b0;
    pc_value_next = pc_value_reg;
    stack_pop_next = 1'b0;
    case (state_reg)
      SPX_IDLE: begin
        if (capture_ok) begin
          state_next = SPX_EXEC;
        end
      end
      SPX_EXEC: begin
        if (cycle_end) begin
          state_next = SPX_IDLE;
          // literal to memory at frame pointer
          if (is_push) begin
            mem_wr_next = '{wr_en: 1'b1, addr: frame_ptr, data: instr_reg[7:0]};
            ptr_wr_next = '{wr_en: 1'b1, sel: `SPX_SEL_FRAME, value: dec_val};
          end else if (is_psub) begin
            ptr_wr_next = '{wr_en: 1'b1, sel: tgt_sel, value: sub_val};
          end
          if (is_ret) begin
            pc_load_next = 1'b1;
            pc_value_next = return_stack_top;
            stack_pop_next = 1'b1;
            state_next = SPX_NOP;
          end
        end
      end
      SPX_NOP: begin
        if (cycle_end) begin
          state_next = SPX_IDLE;
        end
      end
      default: state_next = SPX_IDLE;
    endcase
  end

  // instruction capture at q1
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      instr_reg <= 16'h_0000;
      taken_reg <= 1'b0;
    end else if (clk_en) begin
      taken_reg <= capture_ok;
      if (capture_ok) begin
        instr_reg <= instr_word;
      end
    end
  end

  // busy follows the next state so the output comes from a flop
  wire logic busy_next = (state_next != SPX_IDLE);

  // state and result registers, no flag outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SPX_IDLE;
      mem_wr_reg <= '0;
      ptr_wr_reg <= '0;
      pc_load_reg <= 1'b0;
      pc_value_reg <= 21'h_00_0000;
      stack_pop_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      mem_wr_reg <= mem_wr_next;
      ptr_wr_reg <= ptr_wr_next;
      pc_load_reg <= pc_load_next;
      pc_value_reg <= pc_value_next;
      stack_pop_reg <= stack_pop_next;
      busy_reg <= busy_next;
    end
  end

  assign mem_wr = mem_wr_reg;
  assign ptr_wr = ptr_wr_reg;
  assign pc_load = pc_load_reg;
  assign pc_value = pc_value_reg;
  assign stack_pop = stack_pop_reg;
  assign busy = busy_reg;
  assign instr_taken = taken_reg;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_push_store: assert property (
    clk_en && state_reg == SPX_EXEC && cycle_end && is_push
    |=> mem_wr_reg.wr_en && mem_wr_reg.data == $past(instr_reg[7:0])
        && mem_wr_reg.addr == $past(frame_ptr))
    else $error("push literal store wrong");
  chk_push_dec: assert property (
    clk_en && state_reg == SPX_EXEC && cycle_end && is_push
    |=> ptr_wr_reg.value == mem_wr_reg.addr - 12'h_001 && ptr_wr_reg.sel == 2'h_2)
    else $error("push literal decrement wrong");
  chk_sub_value: assert property (
    clk_en && state_reg == SPX_EXEC && cycle_end && is_psub && !is_ret
    |=> ptr_wr_reg.wr_en && ptr_wr_reg.sel == $past(sel_f)
        && ptr_wr_reg.value == $past(tgt_ptr) - {6'h_0, $past(lit_k)})
    else $error("pointer subtract wrong");
  chk_ret_frame: assert property (
    clk_en && state_reg == SPX_EXEC && cycle_end && is_ret
    |=> ptr_wr_reg.sel == 2'h_2)
    else $error("return subtract not on frame pointer");
  chk_ret_pc: assert property (
    clk_en && state_reg == SPX_EXEC && cycle_end && is_ret
    |=> pc_load_reg && pc_value_reg == $past(return_stack_top))
    else $error("return pc load wrong");
  chk_ret_nop: assert property (
    pc_load_reg |-> state_reg == SPX_NOP && !ptr_wr_next.wr_en && !mem_wr_next.wr_en)
    else $error("second cycle not idle");
  chk_one_cycle: assert property (
    clk_en && $rose(busy) ##1 clk_en [*2] |=> state_reg != SPX_EXEC)
    else $error("execute took more than one cycle");
  chk_gate_ext: assert property (
    (mem_wr_reg.wr_en || ptr_wr_reg.wr_en) |-> $past(extended_set_enable))
    else $error("extended op without enable");
  chk_opcode: assert property (
    ptr_wr_reg.wr_en && !mem_wr_reg.wr_en |-> $past(instr_reg[15:8]) == 8'h_E9)
    else $error("subtract from wrong opcode");

  // quiet cycles and pulse shapes
  chk_nop_quiet: assert property (
    state_reg == SPX_NOP && !pc_load_reg |-> !mem_wr_reg.wr_en && !ptr_wr_reg.wr_en)
    else $error("write during return no operation cycle");
  chk_ret_pop: assert property (
    pc_load_reg |-> stack_pop_reg && ptr_wr_reg.wr_en && ptr_wr_reg.sel == `SPX_SEL_FRAME)
    else $error("return without pop or frame write");
  chk_taken_pulse: assert property (
    clk_en && instr_taken |=> !instr_taken)
    else $error("instruction taken longer than one cycle");
  chk_idle_quiet: assert property (
    $past(clk_en) && !$past(busy) |-> !mem_wr_reg.wr_en && !ptr_wr_reg.wr_en && !pc_load_reg)
    else $error("result pulse outside an instruction cycle");

  // scenario covers
  cov_push: cover property (mem_wr_reg.wr_en);
  cov_sub: cover property (ptr_wr_reg.wr_en && !mem_wr_reg.wr_en && !pc_load_reg);
  cov_ret: cover property (pc_load_reg);
  cov_stall: cover property (!clk_en && busy);
  cov_disabled: cover property ($rose(busy) && !extended_set_enable);
endmodule
`default_nettype wire

/* File: hw/spx_phase.sv */
// four-phase instruction cycle counter
`timescale 1ns/1ps
`default_nettype none
`include "spx_defines.svh"
module spx_phase (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  output logic [1:0] phase,
  output logic cycle_end
);
  logic [1:0] phase_reg;
  // phases q1..q4 repeat
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= 2'h_0;
    end else if (clk_en) begin
      phase_reg <= phase_reg + 2'h_1;
    end
  end
  assign phase = phase_reg;
  assign cycle_end = (phase_reg == `SPX_PHASE_LAST);
endmodule
`default_nettype wire

/* File: hw/spx_pkg.sv */
// types for the stack pointer extended operations block
`default_nettype none
package spx_pkg;
  // memory write request carried to data memory
  typedef struct packed {
    logic wr_en;
    logic [11:0] addr;
    logic [7:0] data;
  } spx_mem_wr_t;
  // pointer write-back request
  typedef struct packed {
    logic wr_en;
    logic [1:0] sel;
    logic [11:0] value;
  } spx_ptr_wr_t;
  // execution states, one-hot
  typedef enum logic [2:0] {
    SPX_IDLE = 3'b001,
    SPX_EXEC = 3'b010,
    SPX_NOP = 3'b100
  } spx_state_t;
endpackage
`default_nettype wire

/* File: tb/stack_pointer_ext_ops_bench.sv */
// self-checking bench for the stack pointer extended operations block
`timescale 1ns/1ps
`default_nettype none
module stack_pointer_ext_ops_bench;
  import spx_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic extended_set_enable = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h_0000;
  logic [35:0] indirect_pointer = 36'h_0_0000_0000;
  logic [20:0] return_stack_top = 21'h_0_0000;
  spx_mem_wr_t mem_wr;
  spx_ptr_wr_t ptr_wr;
  logic pc_load, stack_pop, busy, instr_taken;
  logic [20:0] pc_value;
  int errors = 0;
  int checks_done = 0;
  spx_mem_wr_t mem_seen;
  spx_ptr_wr_t ptr_seen;
  logic [20:0] pc_seen;
  int lat, busy_n, pops;
  int stall_n = 0;

  spx_exec dut_u (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .extended_set_enable(extended_set_enable),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .indirect_pointer(indirect_pointer),
    .return_stack_top(return_stack_top),
    .mem_wr(mem_wr),
    .ptr_wr(ptr_wr),
    .pc_load(pc_load),
    .pc_value(pc_value),
    .stack_pop(stack_pop),
    .busy(busy),
    .instr_taken(instr_taken)
  );

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // compare and count
  task automatic chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // offer one word, then record every pulse for twelve cycles
  task automatic run_op(input logic [15:0] word, input bit need);
    int i;
    mem_seen = '0;
    ptr_seen = '0;
    pc_seen = '0;
    lat = 0;
    busy_n = 0;
    pops = 0;
    instr_word = word;
    instr_valid = 1'b1;
    i = 0;
    while (instr_taken !== 1'b1 && i < 8) begin
      @(negedge sys_clk);
      i++;
    end
    if (need && i == 8) begin
      chk("instr_taken", 21'h_0_0000, 21'h_0_0001);
      end_sim();
    end
    instr_valid = 1'b0;
    // optional freeze of all state before the cycle runs on
    if (stall_n > 0) begin
      clk_en = 1'b0;
      repeat (stall_n) @(negedge sys_clk);
      clk_en = 1'b1;
    end
    for (i = 1; i <= 12; i++) begin
      if (busy === 1'b1) busy_n++;
      if (mem_wr.wr_en === 1'b1) begin
        mem_seen = mem_wr;
        lat = i;
      end
      if (ptr_wr.wr_en === 1'b1) begin
        ptr_seen = ptr_wr;
        lat = i;
      end
      if (pc_load === 1'b1) pc_seen = pc_value;
      if (stack_pop === 1'b1) pops++;
      @(negedge sys_clk);
    end
  endtask

  // word must leave memory, pointers and return stack untouched
  task automatic no_effect(input logic [15:0] word, input string what);
    run_op(word, 1'b0);
    chk({what, " mem_wr"}, 21'(mem_seen.wr_en), 21'h_0_0000);
    chk({what, " ptr_wr"}, 21'(ptr_seen.wr_en), 21'h_0_0000);
    chk({what, " stack_pop"}, 21'(pops), 21'h_0_0000);
  endtask

  task automatic push_case;
    indirect_pointer = {12'h_01EC, 12'h_0AAA, 12'h_0555};
    run_op(16'h_EA08, 1'b1);
    chk("push wr_en", 21'(mem_seen.wr_en), 21'h_0_0001);
    chk("push addr", 21'(mem_seen.addr), 21'h_0_01EC);
    chk("push data", 21'(mem_seen.data), 21'h_0_0008);
    chk("push sel", 21'(ptr_seen.sel), 21'h_0_0002);
    chk("push value", 21'(ptr_seen.value), 21'h_0_01EB);
    chk("push latency", 21'(lat), 21'h_0_0004);
    chk("push busy", 21'(busy_n), 21'h_0_0003);
    chk("push stack_pop", 21'(pops), 21'h_0_0000);
  endtask

  // clock enable low freezes the instruction cycle
  task automatic stall_case;
    indirect_pointer = {12'h_0100, 12'h_0AAA, 12'h_0555};
    stall_n = 3;
    run_op(16'h_EA5A, 1'b1);
    stall_n = 0;
    chk("stall addr", 21'(mem_seen.addr), 21'h_0_0100);
    chk("stall data", 21'(mem_seen.data), 21'h_0_005A);
    chk("stall value", 21'(ptr_seen.value), 21'h_0_00FF);
    chk("stall latency", 21'(lat), 21'h_0_0004);
    chk("stall busy", 21'(busy_n), 21'h_0_0003);
  endtask

  // selectors 0 to 2, plain and wrapping difference
  task automatic subtract_case;
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 2; c++) begin
        indirect_pointer = 36'h_1_1111_1111;
        indirect_pointer[s*12 +: 12] = c ? 12'h_0010 : 12'h_03FF;
        run_op({8'h_E9, s[1:0], c ? 6'h_3F : 6'h_23}, 1'b1);
        chk("sub sel", 21'(ptr_seen.sel), 21'(s));
        chk("sub value", 21'(ptr_seen.value), c ? 21'h_0_0FD1 : 21'h_0_03DC);
        chk("sub mem_wr", 21'(mem_seen.wr_en), 21'h_0_0000);
        chk("sub latency", 21'(lat), 21'h_0_0004);
        chk("sub stack_pop", 21'(pops), 21'h_0_0000);
        chk("sub busy", 21'(busy_n), 21'h_0_0003);
      end
    end
  endtask

  task automatic return_case;
    indirect_pointer = {12'h_03FF, 12'h_0AAA, 12'h_0555};
    return_stack_top = 21'h_1_2345;
    run_op(16'h_E9E3, 1'b1);
    chk("ret sel", 21'(ptr_seen.sel), 21'h_0_0002);
    chk("ret value", 21'(ptr_seen.value), 21'h_0_03DC);
    chk("ret pc", pc_seen, 21'h_1_2345);
    chk("ret stack_pop", 21'(pops), 21'h_0_0001);
    chk("ret busy", 21'(busy_n), 21'h_0_0007);
    chk("ret mem_wr", 21'(mem_seen.wr_en), 21'h_0_0000);
  endtask

  // hang guard
  initial begin
    #200000;
    chk("watchdog", 21'h_0_0000, 21'h_0_0001);
    end_sim();
  end

  // main sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    extended_set_enable = 1'b1;
    push_case();
    subtract_case();
    return_case();
    stall_case();
    no_effect(16'h_EB08, "unknown op");
    extended_set_enable = 1'b0;
    no_effect(16'h_EA08, "disabled push");
    no_effect(16'h_E9E3, "disabled return");
    end_sim();
  end
endmodule
`default_nettype wire
